// ===== etml_chan.sv
// One compare channel: match detect, output level and pin register
`timescale 1ns/10ps
module etml_chan
  import etml_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  logic         clk,
  input  logic         rst_n,
  input  logic         tick,
  input  logic         restart,
  input  etml_chcfg_t  cfg,
  input  logic [W-1:0] cnt,
  input  logic [W-1:0] cmp,
  input  etml_dir_t    dir,
  input  logic [1:0]   align,
  output logic         match,
  output logic         pin
);
  logic dir_ok;
  logic act;
  logic lvl_q;
  logic lvl_d;
  logic pwm_lvl;
  logic pin_q;
  logic pin_d;

  // Centre modes AL_UP and AL_DN match only in their count direction; AL_BOTH matches in either
  assign dir_ok = (align == AL_EDGE) || (align == AL_BOTH)
               || (align == AL_UP && dir == DIR_UP)
               || (align == AL_DN && dir == DIR_DOWN);
  assign match  = tick && (cnt == cmp) && dir_ok;
  // Duty above the period keeps this true all period long
  assign act    = cnt < cmp;

  // Compare-match level: initial level until a match moves it
  always_comb begin
    lvl_d = lvl_q;
    if (restart || cfg.mode != MODE_CMP) begin
      lvl_d = cfg.out_ctrl;
    end else if (match) begin
      case (cfg.outfunc)
        FN_LOW:  lvl_d = 1'b0;
        FN_HIGH: lvl_d = 1'b1;
        FN_TOG:  lvl_d = ~lvl_q;
        default: lvl_d = lvl_q;
      endcase
    end
  end

  // PWM level; single pulse is not built here and rests inactive
  always_comb begin
    case (cfg.outfunc)
      PW_ON:   pwm_lvl = cfg.out_ctrl;
      PW_WAVE: pwm_lvl = act ? cfg.out_ctrl : ~cfg.out_ctrl;
      default: pwm_lvl = ~cfg.out_ctrl;
    endcase
  end

  assign pin_d = ((cfg.mode == MODE_PWM) ? pwm_lvl : lvl_q) ^ cfg.invert;
  assign pin   = pin_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      pin_q <= pin_d;
    end
  end
endmodule : etml_chan

// ===== etml_load.sv
// Load model for the timer output pins: a pulled-down external load
`timescale 1ns/10ps
module etml_load (
  input  wire logic pin,
  input  wire logic oe,
  output logic      level
);
  // A released pin falls to the pull-down level, never keeps its last value
  assign level = oe ? pin : 1'b0;
endmodule : etml_load

// ===== etml_pkg.sv
// Package: constants, types and helpers of the enhanced timer mode logic
// Overview of operation
// - All mode bits zero selects compare-match output
// - Clear-select low: period match or overflow clears
// - Clear-select high: A match clears, no P flag
// - Only A/B matches move compare-match pins
// - Output function sets, clears or toggles pin
// - Pin holds initial level before first match
// - Run rising edge restores initial pin level
// - Timer mode: compare flags, pins not driven
// - Clear-select high: A sets period, B duty
// - Period codes 1..7 give 128..896, 0 gives 1024
// - Edge aligned starts together, centre aligned staggers
// - PWM raises A, B and P match flags
// - Active level, function field and inversion shape pins
// - Duty at or above period gives full duty (centre aligned gives full duty only above period)
// - Alignment field picks edge or centre match direction
// - Function codes: inactive, active, PWM, single pulse (single pulse is not built here and rests inactive)
// - Counter and compare values are ten bits
package etml_pkg;
  localparam int CNT_W = 10;
  localparam int PER_W = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_RUN  = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_CTL2 = 8'h08;
  localparam logic [7:0] OFS_CNT  = 8'h0c;
  localparam logic [7:0] OFS_CMPA = 8'h10;
  localparam logic [7:0] OFS_CMPB = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h18;
  // Field positions
  localparam int RUN_BIT   = 0;
  localparam int PER_LSB   = 4;
  localparam int MODE_LSB  = 6;
  localparam int FUNC_LSB  = 4;
  localparam int OCTL_BIT  = 3;
  localparam int INV_BIT   = 2;
  localparam int CLR_BIT   = 0;
  localparam int ALIGN_LSB = 0;
  localparam int FLAG_A    = 0;
  localparam int FLAG_B    = 1;
  localparam int FLAG_P    = 2;
  // Reset values
  localparam logic [7:0]       CTL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CMP_RST = 10'h000;
  localparam logic [PER_W-1:0] PER_RST = 3'h0;
  // Period arithmetic: field steps of 128, code zero means full count
  localparam int          PER_SHIFT = 7;
  localparam logic [10:0] FULL_SPAN = 11'h400;
  localparam logic [9:0]  CNT_MAX   = 10'h3ff;
  // Timer clock divider default (one tick per system clock)
  localparam int TICK_DIV_DEF = 1;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00, MODE_CAP = 2'b01, MODE_PWM = 2'b10, MODE_TMR = 2'b11
  } etml_mode_t;
  // Compare-match output functions
  localparam logic [1:0] FN_NONE = 2'b00;
  localparam logic [1:0] FN_LOW  = 2'b01;
  localparam logic [1:0] FN_HIGH = 2'b10;
  localparam logic [1:0] FN_TOG  = 2'b11;
  // PWM output functions
  localparam logic [1:0] PW_OFF  = 2'b00;
  localparam logic [1:0] PW_ON   = 2'b01;
  localparam logic [1:0] PW_WAVE = 2'b10;
  localparam logic [1:0] PW_ONE  = 2'b11;
  // Alignment codes
  localparam logic [1:0] AL_EDGE = 2'b00;
  localparam logic [1:0] AL_UP   = 2'b01;
  localparam logic [1:0] AL_DN   = 2'b10;
  localparam logic [1:0] AL_BOTH = 2'b11;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} etml_dir_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] outfunc;
    logic       out_ctrl;
    logic       invert;
  } etml_chcfg_t;

  // Unpack a channel control byte
  function automatic etml_chcfg_t etml_to_cfg(input logic [7:0] b);
    etml_chcfg_t c;
    c.mode     = b[MODE_LSB +: 2];
    c.outfunc  = b[FUNC_LSB +: 2];
    c.out_ctrl = b[OCTL_BIT];
    c.invert   = b[INV_BIT];
    return c;
  endfunction : etml_to_cfg
endpackage : etml_pkg

// ===== etml_top.sv
// Enhanced timer mode logic with AHB-Lite register slave
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module etml_top
  import etml_pkg::*;
#(
  parameter int TICK_DIV = TICK_DIV_DEF
) (
  input  logic        CLK,
  input  logic        RST_N,
  input  logic        HSEL,
  input  logic [31:0] HADDR,
  input  logic [1:0]  HTRANS,
  input  logic        HWRITE,
  input  logic [2:0]  HSIZE,
  input  logic [31:0] HWDATA,
  input  logic        HREADY,
  output logic [31:0] HRDATA,
  output logic        HREADYOUT,
  output logic        HRESP,
  output logic        CHAN_A_PIN,
  output logic        CHAN_A_PIN_OE,
  output logic        CHAN_B_PIN_FIRST,
  output logic        CHAN_B_PIN_FIRST_OE,
  output logic        CHAN_B_PIN_SECOND,
  output logic        CHAN_B_PIN_SECOND_OE
);
  // Bus and register state
  logic             wr_q;
  logic [7:0]       waddr_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rd_mux;
  logic             acc;
  logic             run_q;
  logic             run_d1_q;
  logic [PER_W-1:0] period_field_q;
  logic [7:0]       timer_ctrl_one_q;
  logic [7:0]       timer_ctrl_two_q;
  logic [CNT_W-1:0] compare_a_value_q;
  logic [CNT_W-1:0] compare_b_value_q;
  logic [2:0]       flag_q;
  logic [2:0]       flag_d;
  logic [2:0]       flag_set;
  logic [2:0]       flag_clr;
  // Counter state
  logic [15:0]      div_q;
  logic             tick;
  logic             tick_run;
  logic             restart;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  etml_dir_t        dir_q;
  etml_dir_t        dir_d;
  // Decoded control
  etml_chcfg_t      cfg_a;
  etml_chcfg_t      cfg_b;
  etml_mode_t       mode;
  logic             clear_source_sel;
  logic [1:0]       align_sel;
  logic             is_pwm;
  logic             centre;
  logic [1:0]       chan_align;
  logic [10:0]      per_span;
  logic [10:0]      base;
  logic [CNT_W-1:0] top_c;
  logic [CNT_W-1:0] top_e;
  logic [CNT_W-1:0] top;
  logic             match_a_flag;
  logic             match_b_flag;
  logic             match_period_flag;
  logic             match_a_ch;
  logic             wrap_a;

  // AHB-Lite: zero wait states, always OKAY
  assign acc       = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_q;

  // Read mux sampled in the address phase; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (HADDR[7:0])
      OFS_RUN: begin
        rd_mux[RUN_BIT]           = run_q;
        rd_mux[PER_LSB +: PER_W]  = period_field_q;
      end
      OFS_CTL1: rd_mux[7:0]       = timer_ctrl_one_q;
      OFS_CTL2: rd_mux[7:0]       = timer_ctrl_two_q;
      OFS_CNT:  rd_mux[CNT_W-1:0] = cnt_q;
      OFS_CMPA: rd_mux[CNT_W-1:0] = compare_a_value_q;
      OFS_CMPB: rd_mux[CNT_W-1:0] = compare_b_value_q;
      OFS_FLAG: rd_mux[2:0]       = flag_q;
      default:  rd_mux            = 32'h0000_0000;
    endcase
  end

  // Address phase capture
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_q    <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= acc && HWRITE;
      if (acc) begin
        waddr_q <= HADDR[7:0];
      end
      if (acc && !HWRITE) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Data phase writes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      run_q             <= 1'b0;
      period_field_q    <= PER_RST;
      timer_ctrl_one_q  <= CTL_RST;
      timer_ctrl_two_q  <= CTL_RST;
      compare_a_value_q <= CMP_RST;
      compare_b_value_q <= CMP_RST;
    end else if (wr_q) begin
      case (waddr_q)
        OFS_RUN: begin
          run_q          <= HWDATA[RUN_BIT];
          period_field_q <= HWDATA[PER_LSB +: PER_W];
        end
        OFS_CTL1: timer_ctrl_one_q  <= HWDATA[7:0];
        OFS_CTL2: timer_ctrl_two_q  <= HWDATA[7:0];
        OFS_CMPA: compare_a_value_q <= HWDATA[CNT_W-1:0];
        OFS_CMPB: compare_b_value_q <= HWDATA[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // Mode decode; a mixed pair of modes parks the pins
  assign cfg_a            = etml_to_cfg(timer_ctrl_one_q);
  assign cfg_b            = etml_to_cfg(timer_ctrl_two_q);
  assign mode             = (cfg_a.mode == cfg_b.mode) ? etml_mode_t'(cfg_a.mode)
                                                       : MODE_CAP;
  assign clear_source_sel = timer_ctrl_one_q[CLR_BIT];
  assign align_sel        = timer_ctrl_two_q[ALIGN_LSB +: 2];
  assign is_pwm           = (mode == MODE_PWM);
  assign centre           = is_pwm && (align_sel != AL_EDGE);
  assign chan_align       = centre ? align_sel : AL_EDGE;

  // Period span: field times 128, field zero meaning the full count
  assign per_span = (period_field_q == PER_RST) ? FULL_SPAN
                  : {1'b0, period_field_q, 7'h00};
  assign base     = clear_source_sel ? {1'b0, compare_a_value_q} : per_span;
  // Centre and compare modes turn at base; 1024 is capped so it overflows
  assign top_c    = (base > {1'b0, CNT_MAX}) ? CNT_MAX : base[CNT_W-1:0];
  // Edge PWM counts base states, so it turns one below
  assign top_e    = (base == 11'h000) ? CMP_RST : 10'(base - 11'h001);
  assign top      = (is_pwm && !centre) ? top_e : top_c;

  // Timer clock enable; clock source selection sits outside this block
  assign tick = (div_q == 16'h0000);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= (div_q >= 16'(TICK_DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // Run rising edge restarts the counter and restores pins
  assign restart  = run_q && !run_d1_q;
  assign tick_run = tick && run_q && !restart;

  // Counter: edge counting wraps at top, centre counting bounces
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (restart) begin
      cnt_d = CMP_RST;
      dir_d = DIR_UP;
    end else if (tick_run) begin
      if (!centre) begin
        cnt_d = (cnt_q == top) ? CMP_RST : cnt_q + 10'h001;
      end else begin
        case (dir_q)
          DIR_UP: begin
            if (cnt_q >= top) begin
              dir_d = DIR_DOWN;
              cnt_d = (top == CMP_RST) ? CMP_RST : cnt_q - 10'h001;
            end else begin
              cnt_d = cnt_q + 10'h001;
            end
          end
          DIR_DOWN: begin
            if (cnt_q == CMP_RST) begin
              dir_d = DIR_UP;
              cnt_d = (top == CMP_RST) ? CMP_RST : 10'h001;
            end else begin
              cnt_d = cnt_q - 10'h001;
            end
          end
          default: dir_d = DIR_UP;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_q    <= CMP_RST;
      dir_q    <= DIR_UP;
      run_d1_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      dir_q    <= dir_d;
      run_d1_q <= run_q;
    end
  end

  // Channels A and B
  etml_chan #(.W(CNT_W)) u_chan_a (
    .clk     (CLK),
    .rst_n   (RST_N),
    .tick    (tick_run),
    .restart (restart),
    .cfg     (cfg_a),
    .cnt     (cnt_q),
    .cmp     (compare_a_value_q),
    .dir     (dir_q),
    .align   (chan_align),
    .match   (match_a_ch),
    .pin     (CHAN_A_PIN)
  );
  etml_chan #(.W(CNT_W)) u_chan_b (
    .clk     (CLK),
    .rst_n   (RST_N),
    .tick    (tick_run),
    .restart (restart),
    .cfg     (cfg_b),
    .cnt     (cnt_q),
    .cmp     (compare_b_value_q),
    .dir     (dir_q),
    .align   (chan_align),
    .match   (match_b_flag),
    .pin     (CHAN_B_PIN_FIRST)
  );
  assign CHAN_B_PIN_SECOND = CHAN_B_PIN_FIRST;

  // Edge PWM with A period never reaches A itself, so flag A at the wrap
  assign wrap_a            = tick_run && is_pwm && !centre && clear_source_sel
                          && (cnt_q == top);
  assign match_a_flag      = match_a_ch || wrap_a;
  // P match only exists while the period field clears the counter
  assign match_period_flag = tick_run && !clear_source_sel
                          && (centre ? (dir_q == DIR_DOWN && cnt_q == CMP_RST)
                                     : (cnt_q == top));

  // Sticky flags, write one to clear; a new match beats the clear
  assign flag_set = {match_period_flag, match_b_flag, match_a_flag};
  assign flag_clr = (wr_q && waddr_q == OFS_FLAG) ? HWDATA[2:0] : 3'h0;
  assign flag_d   = (flag_q & ~flag_clr) | flag_set;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flag_q <= 3'h0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Pin function claim: timer mode leaves pins to other functions
  assign CHAN_A_PIN_OE        = (mode == MODE_CMP) || (is_pwm && !clear_source_sel);
  assign CHAN_B_PIN_FIRST_OE  = (mode == MODE_CMP) || is_pwm;
  assign CHAN_B_PIN_SECOND_OE = CHAN_B_PIN_FIRST_OE;

  // Checks
  sequence s_restart_cmp;
    restart && mode == MODE_CMP && compare_a_value_q != CMP_RST;
  endsequence
  sequence s_only_p;
    mode == MODE_CMP && match_period_flag && !match_a_flag && !restart;
  endsequence

  property p_flag_set;
    @(posedge CLK) disable iff (!RST_N) match_a_flag |=> flag_q[FLAG_A];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("A flag missed");

  property p_no_pflag;
    @(posedge CLK) disable iff (!RST_N)
      clear_source_sel && !flag_q[FLAG_P] ##1 clear_source_sel |-> !flag_q[FLAG_P];
  endproperty
  a_no_pflag: assert property (p_no_pflag) else $error("P flag with A clear");

  property p_restart;
    @(posedge CLK) disable iff (!RST_N)
      s_restart_cmp ##1 $stable(cfg_a) |=> CHAN_A_PIN == (cfg_a.out_ctrl ^ cfg_a.invert);
  endproperty
  a_restart: assert property (p_restart) else $error("Pin not restored");

  property p_timer_off;
    @(posedge CLK) disable iff (!RST_N)
      mode == MODE_TMR |-> !CHAN_A_PIN_OE && !CHAN_B_PIN_FIRST_OE && !CHAN_B_PIN_SECOND_OE;
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("Timer mode drives pin");

  property p_cmp_oe;
    @(posedge CLK) disable iff (!RST_N)
      mode == MODE_CMP |-> CHAN_A_PIN_OE && CHAN_B_PIN_FIRST_OE;
  endproperty
  a_cmp_oe: assert property (p_cmp_oe) else $error("Compare pin idle");

  property p_clear;
    @(posedge CLK) disable iff (!RST_N)
      tick_run && !centre && cnt_q == top |=> cnt_q == CMP_RST;
  endproperty
  a_clear: assert property (p_clear) else $error("Counter not cleared");

  property p_p_quiet;
    @(posedge CLK) disable iff (!RST_N)
      s_only_p ##1 ($stable(cfg_a) && !restart) |=> CHAN_A_PIN == $past(CHAN_A_PIN);
  endproperty
  a_p_quiet: assert property (p_p_quiet) else $error("P match moved pin");

  property p_toggle;
    @(posedge CLK) disable iff (!RST_N)
      mode == MODE_CMP && match_a_ch && cfg_a.outfunc == FN_TOG && !restart
      ##1 ($stable(cfg_a) && !restart) |=> CHAN_A_PIN != $past(CHAN_A_PIN);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Pin did not toggle");

  property p_full;
    @(posedge CLK) disable iff (!RST_N)
      is_pwm && cfg_b.mode == MODE_PWM && cfg_b.outfunc == PW_WAVE && cnt_q <= top
      && {1'b0, compare_b_value_q} > {1'b0, top} && $stable(cfg_b)
      |=> CHAN_B_PIN_FIRST == (cfg_b.out_ctrl ^ cfg_b.invert);
  endproperty
  a_full: assert property (p_full) else $error("Duty not full");
endmodule : etml_top

// ===== etml_top_tb.sv
// Self-checking testbench for the enhanced timer mode logic
`timescale 1ns/10ps
module etml_top_tb;
  import etml_pkg::*;
  logic        CLK;
  logic        RST_N;
  logic        HSEL;
  logic [31:0] HADDR;
  logic [1:0]  HTRANS;
  logic        HWRITE;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        pa, pa_oe, pb0, pb0_oe, pb1, pb1_oe;
  logic        lvl_a, lvl_b0, lvl_b1;
  logic [31:0] r;
  int          num_errors;
  int          cmp_count;

  etml_top #(.TICK_DIV(1)) uut (
    .CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CHAN_A_PIN(pa), .CHAN_A_PIN_OE(pa_oe),
    .CHAN_B_PIN_FIRST(pb0), .CHAN_B_PIN_FIRST_OE(pb0_oe),
    .CHAN_B_PIN_SECOND(pb1), .CHAN_B_PIN_SECOND_OE(pb1_oe));
  etml_load u_la (.pin(pa), .oe(pa_oe), .level(lvl_a));
  etml_load u_lb0 (.pin(pb0), .oe(pb0_oe), .level(lvl_b0));
  etml_load u_lb1 (.pin(pb1), .oe(pb1_oe), .level(lvl_b1));

  // Free-running 100 MHz clock
  initial CLK = 1'b0;
  always #5 CLK = ~CLK;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Single AHB-Lite transfer; the bus hready is the slave's own hreadyout
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
    chk({31'h0, HRESP}, 32'h0);
  endtask : bus

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] f,
                                     input logic oc, input logic inv, input logic [1:0] lo);
    return {24'h0, m, f, oc, inv, lo};
  endfunction : ctl

  function automatic logic [31:0] runv(input logic [2:0] p, input logic on);
    return {25'h0, p, 3'b000, on};
  endfunction : runv

  // Stop the counter and clear all flags before reprogramming modes
  task automatic halt();
    bus(1'b1, OFS_RUN, runv(3'h0, 1'b0));
    bus(1'b1, OFS_FLAG, 32'h7);
  endtask : halt

  // PWM run: high-time of each pin over a window of whole periods
  task automatic pwm(input logic [2:0] code, input logic clr, input logic [1:0] al,
                     input logic [1:0] fa, input logic [1:0] fb, input logic inv,
                     input logic [9:0] ca, input logic [9:0] cb, input int win,
                     input int ea, input int eb);
    logic [31:0] ha, hb, hx;
    ha = 0;
    hb = 0;
    hx = 0;
    halt();
    bus(1'b1, OFS_CMPA, {22'h0, ca});
    bus(1'b1, OFS_CMPB, {22'h0, cb});
    bus(1'b1, OFS_CTL1, ctl(MODE_PWM, fa, 1'b1, inv, {1'b0, clr}));
    bus(1'b1, OFS_CTL2, ctl(MODE_PWM, fb, 1'b1, 1'b0, al));
    bus(1'b1, OFS_RUN, runv(code, 1'b1));
    repeat (4) @(posedge CLK);
    // Sample mid-cycle so the pin registers have settled
    repeat (win) begin
      @(negedge CLK);
      ha = ha + 32'(lvl_a);
      hb = hb + 32'(lvl_b0);
      hx = hx + 32'(lvl_b0 ^ lvl_b1);
    end
    chk(ha, 32'(ea));
    chk(hb, 32'(eb));
    chk(hx, 32'h0);
  endtask : pwm

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // Watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge CLK);
    num_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [1:0] f;
    logic       oc;
    logic       ex;
    num_errors = 0;
    cmp_count = 0;
    RST_N = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    #1;
    chk({29'h0, pa_oe, pb0_oe, pb1_oe}, 32'h7);
    chk({29'h0, lvl_a, lvl_b0, lvl_b1}, 32'h0);
    // Reset values, including one unmapped offset that must read zero
    for (int a = 0; a <= 8'h1c; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      chk(r, 32'h0);
    end
    // Every output function from both initial levels, clearing on A
    for (int i = 0; i < 8; i++) begin
      f = 2'(i);
      oc = i[2];
      ex = (f == FN_NONE) ? oc : (f == FN_LOW) ? 1'b0 : (f == FN_HIGH) ? 1'b1 : ~oc;
      halt();
      bus(1'b1, OFS_CMPA, 32'h3);
      bus(1'b1, OFS_CTL1, ctl(MODE_CMP, f, oc, 1'b0, 2'b01));
      bus(1'b1, OFS_RUN, runv(3'h0, 1'b1));
      repeat (3) @(posedge CLK);
      #1 chk(32'(lvl_a), 32'(oc));
      repeat (4) @(posedge CLK);
      #1 chk(32'(lvl_a), 32'(ex));
    end
    // A clears above a lower period value: no period flag, B drives high
    halt();
    bus(1'b1, OFS_CMPA, 32'h12c);
    bus(1'b1, OFS_CMPB, 32'h2);
    bus(1'b1, OFS_CTL2, ctl(MODE_CMP, FN_HIGH, 1'b0, 1'b0, 2'b00));
    bus(1'b1, OFS_RUN, runv(3'h1, 1'b1));
    repeat (700) @(posedge CLK);
    bus(1'b0, OFS_FLAG, 32'h0);
    chk(r, 32'h3);
    chk({30'h0, lvl_b0, lvl_b1}, 32'h3);
    // Period clearing: P flags, counter stays at or below 128, A pin untouched
    halt();
    bus(1'b1, OFS_CMPA, 32'hc8);
    bus(1'b1, OFS_CMPB, 32'hc8);
    bus(1'b1, OFS_CTL1, ctl(MODE_CMP, FN_TOG, 1'b0, 1'b0, 2'b00));
    bus(1'b1, OFS_RUN, runv(3'h1, 1'b1));
    repeat (400) @(posedge CLK);
    bus(1'b0, OFS_FLAG, 32'h0);
    chk(r, 32'h4);
    chk(32'(lvl_a), 32'h0);
    bus(1'b0, OFS_CNT, 32'h0);
    chk(32'(r < 32'd128), 32'h1);
    // Timer mode: flags as in compare mode, pins released
    halt();
    bus(1'b1, OFS_CMPA, 32'h3);
    bus(1'b1, OFS_CTL1, ctl(MODE_TMR, FN_TOG, 1'b1, 1'b0, 2'b01));
    bus(1'b1, OFS_CTL2, ctl(MODE_TMR, FN_TOG, 1'b1, 1'b0, 2'b00));
    bus(1'b1, OFS_RUN, runv(3'h0, 1'b1));
    repeat (20) @(posedge CLK);
    bus(1'b0, OFS_FLAG, 32'h0);
    chk(r & 32'h5, 32'h1);
    chk({29'h0, pa_oe, pb0_oe, pb1_oe}, 32'h0);
    // Mixed channel modes are not permitted and leave the pins released
    bus(1'b1, OFS_CTL1, ctl(MODE_CMP, FN_TOG, 1'b1, 1'b0, 2'b01));
    @(posedge CLK);
    #1 chk({29'h0, pa_oe, pb0_oe, pb1_oe}, 32'h0);
    // Edge-aligned PWM: period codes, full duty, inversion, forced levels
    pwm(3'h1, 1'b0, AL_EDGE, PW_WAVE, PW_WAVE, 1'b0, 10'd32, 10'd64, 256, 64, 128);
    pwm(3'h0, 1'b0, AL_EDGE, PW_WAVE, PW_WAVE, 1'b0, 10'd100, 10'd0, 1024, 100, 0);
    bus(1'b0, OFS_FLAG, 32'h0);
    chk(r, 32'h7);
    pwm(3'h7, 1'b0, AL_EDGE, PW_WAVE, PW_WAVE, 1'b0, 10'd100, 10'd896, 896, 100, 896);
    pwm(3'h1, 1'b0, AL_EDGE, PW_WAVE, PW_WAVE, 1'b1, 10'd32, 10'd200, 256, 192, 256);
    pwm(3'h1, 1'b0, AL_EDGE, PW_OFF, PW_ON, 1'b0, 10'd32, 10'd32, 256, 0, 256);
    // Single pulse is not built: the pin rests at its inactive level
    pwm(3'h1, 1'b0, AL_EDGE, PW_ONE, PW_ON, 1'b0, 10'd32, 10'd32, 256, 0, 256);
    pwm(3'h1, 1'b1, AL_EDGE, PW_WAVE, PW_WAVE, 1'b0, 10'd50, 10'd10, 100, 0, 20);
    // Centre alignment, every direction code: period doubles, duty 2*cmp-1
    for (int al = 1; al < 4; al++) begin
      pwm(3'h1, 1'b0, 2'(al), PW_WAVE, PW_WAVE, 1'b0, 10'd32, 10'd64, 512, 126, 254);
    end
    // Early in the first up-count only an up-matching code may flag A
    for (int al = 1; al < 3; al++) begin
      halt();
      bus(1'b1, OFS_CTL2, ctl(MODE_PWM, PW_WAVE, 1'b1, 1'b0, 2'(al)));
      bus(1'b1, OFS_RUN, runv(3'h1, 1'b1));
      repeat (60) @(posedge CLK);
      bus(1'b0, OFS_FLAG, 32'h0);
      chk(r, 32'(al == 1));
    end
    conclude();
  end
endmodule : etml_top_tb
